/* rtl/spw_regs.v */
/*
 Vendor command registers of a multi-channel supply supervisor: peak
 trackers, direct DAC code, power-good delay, watchdog, global page mask.
 Assumes a command decoder that hands over the command code, page and
 16-bit data with one-cycle strobes, and ADC results with a strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spw_defines.vh"

module spw_regs (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // register access from the command decoder
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_cmd,
  input wire [7:0] i_page,
  input wire [15:0] i_wr_data,
  input wire i_clear_faults,
  output reg [15:0] o_rd_data,
  output reg o_rd_valid,
  // measurements
  input wire i_vin_stb,
  input wire [15:0] i_vin_value,
  input wire i_temp_stb,
  input wire [15:0] i_temp_value,
  // configuration from other registers
  input wire [1:0] i_dac_mode,
  input wire i_pg_uses_watchdog,
  // power good
  input wire i_pg_internal,
  output reg o_power_good,
  // watchdog
  input wire i_wd_kick,
  output reg o_wd_timeout,
  output reg o_wd_running,
  // dac and global page
  output reg [9:0] o_dac_code,
  output reg [7:0] o_global_chan_en
);

  reg [15:0] vin_peak;
  reg [15:0] temp_peak;
  reg [15:0] pg_delay;
  reg [15:0] wd_first;
  reg [15:0] wd_repeat;
  reg [7:0] page_mask;
  reg [8:0] tick_cnt;
  reg tick;
  reg [31:0] pg_cnt;
  reg pg_int_q;
  reg [31:0] wd_cnt;
  reg wd_in_first;
  reg wd_was_en;
  reg pg_q;
  wire [31:0] pg_ticks;
  wire [31:0] wdf_ticks;
  wire [31:0] wdr_ticks;
  wire wdf_zero;
  wire wdr_zero;
  wire pg_unused;
  wire wd_enable;
  wire wd_restart;

  function greater;
    input [15:0] a;
    input [15:0] b;
    reg signed [4:0] ea;
    reg signed [4:0] eb;
    reg signed [47:0] va;
    reg signed [47:0] vb;
    begin
      ea = a[15:11];
      eb = b[15:11];
      va = {{37{a[10]}}, a[10:0]};
      vb = {{37{b[10]}}, b[10:0]};
      // scale both onto a common exponent of -16
      va = va <<< (ea + 6'sd16);
      vb = vb <<< (eb + 6'sd16);
      greater = (va > vb);
    end
  endfunction

  // delay rounded, clipped at 13.1 s
  spw_lin_to_ticks #(
    .STEP_TICKS(`SPW_PG_STEP_US / `SPW_TICK_US),
    .MAX_TICKS(`SPW_PG_MAX_TICKS)
  ) u_pg_conv (
    .i_value(pg_delay),
    .o_ticks(pg_ticks),
    .o_zero(pg_unused)
  );

  // first interval rounded to 1 ms
  // first interval clipped at 65 s
  spw_lin_to_ticks #(
    .STEP_TICKS(`SPW_WDF_STEP_US / `SPW_TICK_US),
    .MAX_TICKS(`SPW_WDF_MAX_TICKS)
  ) u_wdf_conv (
    .i_value(wd_first),
    .o_ticks(wdf_ticks),
    .o_zero(wdf_zero)
  );

  // repeat interval rounded to 10 us
  // repeat interval clipped at 0.6 s
  spw_lin_to_ticks #(
    .STEP_TICKS(`SPW_WDR_STEP_US / `SPW_TICK_US),
    .MAX_TICKS(`SPW_WDR_MAX_TICKS)
  ) u_wdr_conv (
    .i_value(wd_repeat),
    .o_ticks(wdr_ticks),
    .o_zero(wdr_zero)
  );

  // internal time base, not the shared clock
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      tick_cnt <= 9'h000;
      tick <= 1'b0;
    end else if (tick_cnt == `SPW_TICK_CYCLES - 1) begin
      tick_cnt <= 9'h000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 9'h001;
      tick <= 1'b0;
    end
  end

  // register writes
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_dac_code <= `SPW_DAC_RESET;
      pg_delay <= `SPW_PG_DELAY_RESET;
      wd_first <= `SPW_WD_RESET;
      wd_repeat <= `SPW_WD_RESET;
      page_mask <= `SPW_MASK_RESET;
    end else if (i_wr_stb) begin
      if (i_cmd == `SPW_CMD_DAC) begin
        if (i_dac_mode == `SPW_DAC_MODE_MAN_SOFT ||
            i_dac_mode == `SPW_DAC_MODE_MAN_HARD)
          o_dac_code <= i_wr_data[9:0];
      end else if (i_cmd == `SPW_CMD_PG_DELAY) begin
        pg_delay <= i_wr_data;
      end else if (i_cmd == `SPW_CMD_WD_FIRST) begin
        wd_first <= i_wr_data;
      end else if (i_cmd == `SPW_CMD_WD_REPEAT) begin
        wd_repeat <= i_wr_data;
      end else if (i_cmd == `SPW_CMD_PAGE_MASK) begin
        page_mask <= i_wr_data[7:0];
      end
    end
  end

  // peak trackers; clear wins since it restarts tracking
  always @(posedge i_ref_clk) begin
    if (i_rst || i_clear_faults) begin
      vin_peak <= `SPW_PEAK_RESET;
    end else if (i_vin_stb && greater(i_vin_value, vin_peak)) begin
      vin_peak <= i_vin_value;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst || i_clear_faults) begin
      temp_peak <= `SPW_PEAK_RESET;
    end else if (i_temp_stb && greater(i_temp_value, temp_peak)) begin
      temp_peak <= i_temp_value;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      pg_cnt <= 32'h0;
      pg_int_q <= 1'b0;
      pg_q <= 1'b0;
    end else begin
      pg_int_q <= i_pg_internal;
      if (!i_pg_internal) begin
        pg_cnt <= 32'h0;
        pg_q <= 1'b0;
      end else if (!pg_int_q) begin
        pg_cnt <= 32'h0;
        pg_q <= (pg_ticks == 32'h0);
      end else if (!pg_q) begin
        if (pg_cnt >= pg_ticks)
          pg_q <= 1'b1;
        else if (tick)
          pg_cnt <= pg_cnt + 32'h1;
      end
    end
  end

  assign wd_enable = !wdf_zero && !wdr_zero;
  assign wd_restart = i_wr_stb && (i_cmd == `SPW_CMD_WD_REPEAT) &&
                      (i_wr_data[10:0] != 11'h000);

  // watchdog: held off until power good when gated on it
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      wd_cnt <= 32'h0;
      wd_in_first <= 1'b1;
      wd_was_en <= 1'b0;
      o_wd_timeout <= 1'b0;
      o_wd_running <= 1'b0;
    end else begin
      wd_was_en <= wd_enable;
      o_wd_timeout <= 1'b0;
      if (!wd_enable) begin
        wd_cnt <= 32'h0;
        wd_in_first <= 1'b1;
        o_wd_running <= 1'b0;
      // gated mode waits for power good
      end else if (i_pg_uses_watchdog && !pg_q) begin
        wd_cnt <= 32'h0;
        wd_in_first <= 1'b1;
        o_wd_running <= 1'b0;
      end else if (!wd_was_en) begin
        wd_cnt <= 32'h0;
        wd_in_first <= 1'b1;
        o_wd_running <= 1'b1;
      end else if (wd_restart || i_wd_kick) begin
        wd_cnt <= 32'h0;
        wd_in_first <= 1'b0;
        o_wd_running <= 1'b1;
      end else begin
        o_wd_running <= 1'b1;
        if (wd_cnt >= (wd_in_first ? wdf_ticks : wdr_ticks)) begin
          o_wd_timeout <= 1'b1;
          wd_cnt <= 32'h0;
          wd_in_first <= 1'b0;
        end else if (tick) begin
          wd_cnt <= wd_cnt + 32'h1;
        end
      end
    end
  end

  // outputs
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_power_good <= 1'b0;
      o_global_chan_en <= 8'h00;
    end else begin
      o_power_good <= pg_q;
      if (i_wr_stb && i_page == `SPW_PAGE_GLOBAL &&
          (i_cmd == `SPW_CMD_OPERATION ||
           i_cmd == `SPW_CMD_ON_OFF_CONFIG))
        o_global_chan_en <= page_mask;
      else
        o_global_chan_en <= 8'h00;
    end
  end

  // read mux
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        if (i_cmd == `SPW_CMD_VIN_PEAK)
          o_rd_data <= vin_peak;
        else if (i_cmd == `SPW_CMD_TEMP_PEAK)
          o_rd_data <= temp_peak;
        else if (i_cmd == `SPW_CMD_DAC)
          o_rd_data <= {`SPW_DAC_UPPER, o_dac_code};
        else if (i_cmd == `SPW_CMD_PG_DELAY)
          o_rd_data <= pg_delay;
        else if (i_cmd == `SPW_CMD_WD_FIRST)
          o_rd_data <= wd_first;
        else if (i_cmd == `SPW_CMD_WD_REPEAT)
          o_rd_data <= wd_repeat;
        else if (i_cmd == `SPW_CMD_PAGE_MASK)
          o_rd_data <= {8'h00, page_mask};
        else
          o_rd_data <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/spw_defines.vh */
/*
 Constants for the supervisor peak, delay and watchdog register bank:
 command codes, reset values, field positions and timing counts.
 Assumes the 40 MHz reference clock and a 16-bit register data path.
*/
`ifndef SPW_DEFINES_VH
`define SPW_DEFINES_VH

// command codes (vendor-specific range, except SPW_CMD_OPERATION, SPW_CMD_ON_OFF_CONFIG and SPW_PAGE_GLOBAL)
`define SPW_CMD_VIN_PEAK 8'hDD
`define SPW_CMD_TEMP_PEAK 8'hDF
`define SPW_CMD_DAC 8'hE0
`define SPW_CMD_PG_DELAY 8'hE1
`define SPW_CMD_WD_FIRST 8'hE2
`define SPW_CMD_WD_REPEAT 8'hE3
`define SPW_CMD_PAGE_MASK 8'hE4
`define SPW_CMD_OPERATION 8'h01
`define SPW_CMD_ON_OFF_CONFIG 8'h02
`define SPW_PAGE_GLOBAL 8'hFF

// reset values
`define SPW_PEAK_RESET 16'h7C00
`define SPW_DAC_UPPER 6'h3F
`define SPW_DAC_RESET 10'h000
`define SPW_PG_DELAY_RESET 16'h0000
`define SPW_WD_RESET 16'h0000
`define SPW_MASK_RESET 8'hFF

// linear format fields
`define SPW_EXP_MSB 15
`define SPW_EXP_LSB 11
`define SPW_MAN_MSB 10
`define SPW_MAN_LSB 0

// dac mode encodings
`define SPW_DAC_MODE_MAN_SOFT 2'h1
`define SPW_DAC_MODE_MAN_HARD 2'h2

// time base: one tick every 10 us at 40 MHz
`define SPW_CLK_MHZ 40
`define SPW_TICK_US 10
`define SPW_TICK_CYCLES (`SPW_TICK_US * `SPW_CLK_MHZ)
// microseconds per rounding step of each timer
`define SPW_PG_STEP_US 200
`define SPW_WDF_STEP_US 1000
`define SPW_WDR_STEP_US 10
// limits in 10 us ticks
`define SPW_PG_MAX_TICKS 32'd1310000
`define SPW_WDR_MAX_TICKS 32'd60000
`define SPW_WDF_MAX_TICKS 32'd6500000

`endif

/* rtl/spw_lin_to_ticks.v */
/*
 Converts a linear-format millisecond value into a count of 10 us ticks,
 rounded to a given step and clipped to a maximum.
 Assumes the value is combinational; the result is combinational too.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spw_defines.vh"

module spw_lin_to_ticks #(
  parameter STEP_TICKS = 1,
  parameter [31:0] MAX_TICKS = 32'd1
) (
  // linear value in ms
  input wire [15:0] i_value,
  // result
  output reg [31:0] o_ticks,
  output reg o_zero
);

  reg signed [4:0] exp_v;
  reg signed [10:0] man_v;
  reg [63:0] us_x1024;
  reg [63:0] ticks;
  reg [63:0] half;
  always @* begin
    exp_v = i_value[`SPW_EXP_MSB:`SPW_EXP_LSB];
    man_v = i_value[`SPW_MAN_MSB:`SPW_MAN_LSB];
    o_zero = (man_v == 11'sd0);
    us_x1024 = 64'h0;
    // negative mantissa means no time at all
    if (!man_v[10]) begin
      us_x1024 = {53'h0, man_v} * 64'd1000 * 64'd65536;
      if (exp_v[4])
        us_x1024 = us_x1024 >> (~exp_v + 5'sd1);
      else
        us_x1024 = us_x1024 << exp_v;
      us_x1024 = us_x1024 >> 6;
    end
    // round to nearest step, in ticks of 10 us
    half = 64'd1024 * `SPW_TICK_US * STEP_TICKS / 2;
    ticks = (us_x1024 + half) / (64'd1024 * `SPW_TICK_US * STEP_TICKS);
    ticks = ticks * STEP_TICKS;
    if (ticks > {32'h0, MAX_TICKS})
      o_ticks = MAX_TICKS;
    else
      o_ticks = ticks[31:0];
  end

endmodule
`default_nettype wire

/* sim/spw_regs_props.sv */
/*
 checker: port-level properties of the peak, delay and watchdog bank.
 assumes one clock domain and is bound to every spw_regs instance.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spw_defines.vh"
module spw_regs_props (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // access
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] i_cmd,
  input wire [7:0] i_page,
  input wire [15:0] i_wr_data,
  input wire i_clear_faults,
  input wire [15:0] o_rd_data,
  input wire o_rd_valid,
  // status and outputs
  input wire i_vin_stb,
  input wire [1:0] i_dac_mode,
  input wire i_pg_internal,
  input wire o_power_good,
  input wire o_wd_timeout,
  input wire o_wd_running,
  input wire [9:0] o_dac_code,
  input wire [7:0] o_global_chan_en
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire dac_man = i_dac_mode == 2'h1 || i_dac_mode == 2'h2;
  wire dac_wr = i_wr_stb && i_cmd == `SPW_CMD_DAC;
  wire glob = i_page == 8'hFF && (i_cmd == 8'h01 || i_cmd == 8'h02);
  a_dac_upper: assert property (
    o_rd_valid && $past(i_cmd) == `SPW_CMD_DAC |-> o_rd_data[15:10] == 6'h3F)
    else $error("dac upper bits wrong");
  a_dac_locked: assert property (
    dac_wr && !dac_man |=> $stable(o_dac_code))
    else $error("dac written while locked");
  a_dac_taken: assert property (
    dac_wr && dac_man |=> o_dac_code == $past(i_wr_data[9:0]))
    else $error("dac write lost");
  a_peak_clear: assert property (
    i_clear_faults ##1 !i_vin_stb ##1
    (i_rd_stb && i_cmd == `SPW_CMD_VIN_PEAK && !i_vin_stb)
    |=> o_rd_data == 16'h7C00)
    else $error("peak not cleared");
  a_pg_drop: assert property (
    $fell(i_pg_internal) |-> ##2 !o_power_good)
    else $error("power good held after drop");
  a_pg_cause: assert property (
    o_power_good |-> $past(i_pg_internal, 2))
    else $error("power good without condition");
  a_wd_pulse: assert property (
    o_wd_timeout |=> !o_wd_timeout)
    else $error("timeout longer than a cycle");
  a_wd_zero_off: assert property (
    i_wr_stb && i_cmd == `SPW_CMD_WD_REPEAT && i_wr_data[10:0] == 11'h000
    |-> ##[1:2] !o_wd_running)
    else $error("watchdog not disabled");
  a_global_only: assert property (
    o_global_chan_en != 8'h00 |-> $past(i_wr_stb && glob))
    else $error("channel enable without global write");
  c_timeout: cover property (o_wd_timeout);
  c_pg_up: cover property ($rose(o_power_good));
  c_global: cover property (o_global_chan_en != 8'h00);
endmodule
bind spw_regs spw_regs_props u_props (.*);
`default_nettype wire

/* sim/spw_host.sv */
/*
 host model: issues register reads and writes with one-cycle strobes.
 assumes the bank answers a read with a valid pulse a cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module spw_host (
  // clock
  input wire i_ref_clk,
  // requests
  output logic o_wr_stb = 0,
  output logic o_rd_stb = 0,
  output logic [7:0] o_cmd = 0,
  output logic [7:0] o_page = 0,
  output logic [15:0] o_data = 0,
  // answer
  input wire [15:0] i_rd_data,
  input wire i_rd_valid
);
  // dac writes go out as any write
  task automatic wr(input logic [7:0] c, p, input logic [15:0] d);
    @(posedge i_ref_clk);
    #1;
    {o_cmd, o_page, o_data, o_wr_stb} = {c, p, d, 1'b1};
    @(posedge i_ref_clk);
    #1;
    o_wr_stb = 0;
    // released command and data lines must not keep their value
    {o_cmd, o_data} = ~{c, d};
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(posedge i_ref_clk);
    #1;
    {o_cmd, o_rd_stb} = {c, 1'b1};
    @(posedge i_ref_clk);
    #1;
    {o_cmd, o_rd_stb} = {~c, 1'b0};
    n = 0;
    while (!i_rd_valid && n < 3) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    d = i_rd_valid ? i_rd_data : 'x;
  endtask
endmodule
`default_nettype wire

/* sim/spw_regs_test.sv */
/*
 testbench: register reads and writes with expected values.
 assumes the host model drives the access port of the bank.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module spw_regs_test;
  logic clk, rst, clr, vs, ts, pgi, kick, pg, to, run, wr, rd, rv, pgw;
  logic [15:0] vin, temp, d, wd, rdat, e;
  logic [7:0] cmd, page, cen;
  logic [1:0] mode;
  logic [9:0] dac;
  int n_errors = 0;
  int total_checks = 0;
  spw_host u_host (.i_ref_clk(clk), .o_wr_stb(wr), .o_rd_stb(rd),
    .o_cmd(cmd), .o_page(page), .o_data(wd), .i_rd_data(rdat),
    .i_rd_valid(rv));
  spw_regs u_dut (.i_ref_clk(clk), .i_rst(rst), .i_wr_stb(wr),
    .i_rd_stb(rd), .i_cmd(cmd), .i_page(page), .i_wr_data(wd),
    .i_clear_faults(clr), .o_rd_data(rdat), .o_rd_valid(rv),
    .i_vin_stb(vs), .i_vin_value(vin), .i_temp_stb(ts),
    .i_temp_value(temp), .i_dac_mode(mode), .i_pg_uses_watchdog(pgw),
    .i_pg_internal(pgi), .o_power_good(pg), .i_wd_kick(kick),
    .o_wd_timeout(to), .o_wd_running(run), .o_dac_code(dac),
    .o_global_chan_en(cen));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic final_report;
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_rd(input string n, input logic [7:0] c,
                        input logic [15:0] x);
    u_host.rd(c, d);
    `CHK(n, x, d)
  endtask
  task automatic wd_wait(input string n, input int x);
    int c;
    c = 0;
    do begin
      tick(1);
      c++;
    end while (to !== 1'b1 && c < x + 50);
    // start phase against the 10 us time base costs up to one tick
    `CHK(n, 1'b1, c > x - 420 && c < x + 20)
  endtask
  initial begin
    {rst, clr, vs, ts, pgi, kick, pgw} = 7'h40;
    {mode, vin, temp} = {2'h0, 32'h0};
    tick(5);
    rst = 0;
    chk_rd("vin_rst", 8'hDD, 16'h7C00);
    chk_rd("temp_rst", 8'hDF, 16'h7C00);
    chk_rd("dac_rst", 8'hE0, 16'hFC00);
    chk_rd("unmapped", 8'h55, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      vin = i == 1 ? 16'h0810 : 16'h0010 + 16'(i * 4);
      vs = 1;
      tick(1);
      vs = 0;
    end
    chk_rd("vin_peak", 8'hDD, 16'h0810);
    {temp, ts} = {16'h0005, 1'b1};
    tick(1);
    ts = 0;
    chk_rd("temp_peak", 8'hDF, 16'h0005);
    clr = 1;
    tick(1);
    clr = 0;
    chk_rd("vin_clr", 8'hDD, 16'h7C00);
    chk_rd("temp_clr", 8'hDF, 16'h7C00);
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      u_host.wr(8'hE0, 8'h00, 16'h0100 + 16'(m));
      e = m == 0 ? 16'hFC00 : m == 3 ? 16'hFD02 : 16'hFD00 + 16'(m);
      chk_rd("dac", 8'hE0, e);
      `CHK("dac_out", e[9:0], dac)
    end
    u_host.wr(8'hE4, 8'h00, 16'h00A5);
    for (int k = 0; k < 4; k++) begin
      u_host.wr(8'(k % 3 + 1), k == 3 ? 8'h00 : 8'hFF, 16'h0080);
      `CHK("glob_en", k < 2 ? 8'hA5 : 8'h00, cen)
    end
    u_host.wr(8'hE1, 8'h00, 16'hF001);
    pgi = 1;
    // 20 ticks of 400 cycles, first tick lands anywhere in 400 cycles
    tick(7500);
    `CHK("pg_early", 1'b0, pg)
    tick(600);
    `CHK("pg_late", 1'b1, pg)
    pgi = 0;
    tick(3);
    `CHK("pg_drop", 1'b0, pg)
    u_host.wr(8'hE3, 8'h00, 16'hF001);
    u_host.wr(8'hE2, 8'h00, 16'h0001);
    wd_wait("wd_first", 40000);
    wd_wait("wd_repeat", 10000);
    tick(5000);
    kick = 1;
    tick(1);
    kick = 0;
    wd_wait("wd_kick", 10000);
    tick(5000);
    u_host.wr(8'hE3, 8'h00, 16'hF001);
    wd_wait("wd_rewrite", 10000);
    `CHK("wd_on", 1'b1, run)
    u_host.wr(8'hE3, 8'h00, 16'h0000);
    tick(2);
    `CHK("wd_off", 1'b0, run)
    pgw = 1;
    u_host.wr(8'hE1, 8'h00, 16'h0000);
    u_host.wr(8'hE3, 8'h00, 16'hF001);
    tick(2);
    `CHK("wd_gated", 1'b0, run)
    pgi = 1;
    tick(4);
    `CHK("pg_nodelay", 1'b1, pg)
    `CHK("wd_gate_open", 1'b1, run)
    final_report;
  end
  initial begin
    #2_450_000;
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
